// ==== fawc_pkg.sv ====
// Package with constants and types of the flash access and wait control block.
package fawc_pkg;

  // Module count and widths.
  localparam int unsigned FAWC_NUM_MODULES = 8;
  localparam int unsigned FAWC_MOD_W       = 3;
  localparam int unsigned FAWC_ADDR_W      = 24;
  localparam int unsigned FAWC_DATA_W      = 16;
  localparam int unsigned FAWC_WS_W        = 3;
  localparam int unsigned FAWC_WSE_W       = 1;
  localparam int unsigned FAWC_CNT_W       = 16;

  // Module address field sits above the module offset bits.
  localparam int unsigned FAWC_MOD_LSB     = 18;

  // Module that may be written while any number of other modules are read, as long as fewer than FAWC_MAX_PARALLEL are busy.
  localparam logic [2:0]  FAWC_FREE_MODULE = 3'h6;

  // Most modules erased or programmed at once with a single read source.
  localparam int unsigned FAWC_MAX_PARALLEL = 7;

  // System clock and operation limits.
  localparam int unsigned FAWC_CLK_KHZ     = 10000;
  localparam int unsigned FAWC_ERASE_US    = 8000;
  localparam int unsigned FAWC_PROG_US     = 3500;
  localparam int unsigned FAWC_ERASE_CYC   = FAWC_ERASE_US * FAWC_CLK_KHZ / 1000;
  localparam int unsigned FAWC_PROG_CYC    = FAWC_PROG_US * FAWC_CLK_KHZ / 1000;

  // Extra system cycles the control sequencer spends around each operation.
  localparam logic [3:0]  FAWC_SEQ_OVERHEAD = 4'h4;

  // Erased flash reads as all ones.
  localparam logic [15:0] FAWC_ERASED_WORD = 16'hffff;

  // Read source codes.
  localparam logic [1:0]  FAWC_SRC_NONE    = 2'h0;
  localparam logic [1:0]  FAWC_SRC_FLASH   = 2'h1;
  localparam logic [1:0]  FAWC_SRC_PROGRAM_SRAM   = 2'h2;

  typedef enum logic [1:0] {
    FAWC_OP_ERASE = 2'b00,
    FAWC_OP_PROG  = 2'b01
  } fawc_op_t;

  typedef enum logic [1:0] {
    FAWC_RD_IDLE = 2'b00,
    FAWC_RD_WAIT = 2'b01,
    FAWC_RD_DONE = 2'b10
  } fawc_rd_state_t;

  typedef enum logic [1:0] {
    FAWC_NV_SETUP = 2'b00,
    FAWC_NV_RUN   = 2'b01,
    FAWC_NV_TAIL  = 2'b10,
    FAWC_NV_IDLE  = 2'b11
  } fawc_nv_state_t;

endpackage

// ==== fawc_nv_if.sv ====
// Interface between the access controller and one module operation timer.
`timescale 1ns/1ns
`default_nettype none
interface fawc_nv_if;
  logic       start;
  logic       is_prog;
  logic       busy;
  logic       done;
  modport ctrl  (output start, output is_prog, input busy, input done);
  modport timer (input start, input is_prog, output busy, output done);
endinterface
`default_nettype wire

// ==== fawc_nv_timer.sv ====
// Erase and program sequencer for one flash module.
`timescale 1ns/1ns
`default_nettype none
module fawc_nv_timer
  import fawc_pkg::*;
#(
  parameter int unsigned ERASE_CYC = FAWC_ERASE_CYC,
  parameter int unsigned PROG_CYC  = FAWC_PROG_CYC
) (
  // Clock and reset.
  input  wire logic  clk_sys,
  input  wire logic  reset_n,
  // Control link.
  fawc_nv_if.timer   nv
);

  fawc_nv_state_t            st_q, st_d;
  logic [FAWC_CNT_W+1:0]     cnt_q, cnt_d;
  logic                      done_q, done_d;
  logic                      prog_q, prog_d;

  // Each operation is setup, the timed run and a short tail.
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    prog_d = prog_q;
    case (st_q)
      FAWC_NV_IDLE: begin
        if (nv.start) begin
          st_d  = FAWC_NV_SETUP;
          // The operation kind is held from start, since the request lines move on.
          prog_d = nv.is_prog;
          cnt_d = (FAWC_CNT_W+2)'(FAWC_SEQ_OVERHEAD);
        end
      end
      FAWC_NV_SETUP: begin
        if (cnt_q <= (FAWC_CNT_W+2)'(1)) begin
          st_d  = FAWC_NV_RUN;
          cnt_d = prog_q ? (FAWC_CNT_W+2)'(PROG_CYC) : (FAWC_CNT_W+2)'(ERASE_CYC);
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      FAWC_NV_RUN: begin
        if (cnt_q <= (FAWC_CNT_W+2)'(1)) begin
          st_d  = FAWC_NV_TAIL;
          cnt_d = (FAWC_CNT_W+2)'(FAWC_SEQ_OVERHEAD);
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      FAWC_NV_TAIL: begin
        if (cnt_q <= (FAWC_CNT_W+2)'(1)) begin
          st_d   = FAWC_NV_IDLE;
          done_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: st_d = FAWC_NV_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q   <= FAWC_NV_IDLE;
      cnt_q  <= '0;
      done_q <= 1'b0;
      prog_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
      prog_q <= prog_d;
    end
  end

  assign nv.busy = (st_q != FAWC_NV_IDLE);
  assign nv.done = done_q;

endmodule
`default_nettype wire

// ==== fawc_flash_ctrl.sv ====
// Flash access controller: read wait states, prefetch and erase/program arbitration.
`timescale 1ns/1ns
`default_nettype none
module fawc_flash_ctrl
  import fawc_pkg::*;
#(
  parameter int unsigned ERASE_CYC = FAWC_ERASE_CYC,
  parameter int unsigned PROG_CYC  = FAWC_PROG_CYC
) (
  // Clock and reset.
  input  wire logic                       clk_sys,
  input  wire logic                       reset_n,
  // Wait state configuration from the memory bus control.
  input  wire logic [FAWC_WS_W-1:0]       flash_wait_state_count,
  input  wire logic [FAWC_WSE_W-1:0]      wait_state_extension,
  // Read request from the internal memory bus.
  input  wire logic                       rd_req,
  input  wire logic [FAWC_ADDR_W-1:0]     rd_addr,
  input  wire logic [1:0]                 rd_src,
  input  wire logic [FAWC_DATA_W-1:0]     array_rdata,
  output logic                            rd_ready,
  output logic [FAWC_DATA_W-1:0]          rd_data,
  output logic                            prefetch_hit,
  // Erase and program requests.
  input  wire logic                       nv_req,
  input  wire logic                       nv_prog,
  input  wire logic [FAWC_MOD_W-1:0]      nv_module,
  input  wire logic [FAWC_NUM_MODULES-1:0] read_active,
  output logic                            nv_accept,
  output logic                            nv_refused,
  output logic [FAWC_NUM_MODULES-1:0]     nv_busy,
  output logic [FAWC_NUM_MODULES-1:0]     nv_done,
  output logic                            protect_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Read path with wait states and one-word prefetch.

  function automatic logic [FAWC_MOD_W-1:0] mod_of(input logic [FAWC_ADDR_W-1:0] a);
    mod_of = a[FAWC_MOD_LSB +: FAWC_MOD_W];
  endfunction

  fawc_rd_state_t             rs_q, rs_d;
  logic [FAWC_WS_W:0]         wcnt_q, wcnt_d;
  logic [FAWC_ADDR_W-1:0]     next_q, next_d;
  logic                       pf_valid_q, pf_valid_d;
  logic [FAWC_DATA_W-1:0]     data_q, data_d;
  logic                       rdy_q, rdy_d;
  logic                       hit_q, hit_d;
  logic                       seq;
  logic [FAWC_NUM_MODULES-1:0] nv_busy_w;

  assign seq = pf_valid_q && (rd_addr == next_q);

  always_comb begin
    rs_d       = rs_q;
    wcnt_d     = wcnt_q;
    next_d     = next_q;
    pf_valid_d = pf_valid_q;
    data_d     = data_q;
    rdy_d      = 1'b0;
    hit_d      = 1'b0;
    case (rs_q)
      FAWC_RD_IDLE: begin
        if (rd_req && rd_src == FAWC_SRC_FLASH) begin
          // sequential bypass: prefetched word answers at once.
          if (seq) begin
            rdy_d  = 1'b1;
            hit_d  = 1'b1;
            data_d = array_rdata;
            next_d = rd_addr + 1'b1;
            rs_d   = FAWC_RD_DONE;
          end else begin
            wcnt_d = {1'b0, flash_wait_state_count}
                     + (FAWC_WS_W+1)'(wait_state_extension);
            rs_d   = FAWC_RD_WAIT;
          end
        end
      end
      FAWC_RD_WAIT: begin
        if (wcnt_q <= (FAWC_WS_W+1)'(1)) begin
          rdy_d      = 1'b1;
          data_d     = array_rdata;
          next_d     = rd_addr + 1'b1;
          pf_valid_d = 1'b1;
          rs_d       = FAWC_RD_DONE;
        end else begin
          wcnt_d = wcnt_q - 1'b1;
        end
      end
      FAWC_RD_DONE: rs_d = FAWC_RD_IDLE;
      default:      rs_d = FAWC_RD_IDLE;
    endcase
    // A write on the module under prefetch drops the stale word.
    if (|(nv_busy_w & (FAWC_NUM_MODULES'(1) << mod_of(next_q)))) begin
      pf_valid_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Erase and program arbitration.

  logic [FAWC_NUM_MODULES-1:0] nv_done_w;
  logic [FAWC_NUM_MODULES-1:0] start_w;
  logic [3:0]                  n_busy;
  logic [3:0]                  n_read;
  logic                        allow;
  logic                        acc_d, ref_d;
  logic                        acc_q, ref_q;

  always_comb begin
    n_busy = '0;
    n_read = '0;
    for (int i = 0; i < FAWC_NUM_MODULES; i++) begin
      n_busy = n_busy + 4'(nv_busy_w[i]);
      n_read = n_read + 4'(read_active[i]);
    end
    allow = 1'b0;
    if (read_active[nv_module] || nv_busy_w[nv_module]) begin
      allow = 1'b0;
    end else if (nv_module == FAWC_FREE_MODULE) begin
      allow = (n_busy < 4'(FAWC_MAX_PARALLEL));
    end else if (n_read <= 4'h1) begin
      allow = (n_busy < 4'(FAWC_MAX_PARALLEL));
    end else begin
      allow = (n_busy == 4'h0);
    end
    acc_d      = nv_req && allow;
    ref_d      = nv_req && !allow;
    start_w    = acc_d ? (FAWC_NUM_MODULES'(1) << nv_module) : '0;
  end

  generate
    for (genvar g = 0; g < FAWC_NUM_MODULES; g++) begin : g_mod
      fawc_nv_if nv ();
      assign nv.start   = start_w[g];
      assign nv.is_prog = nv_prog;
      assign nv_busy_w[g] = nv.busy;
      assign nv_done_w[g] = nv.done;
      fawc_nv_timer #(
        .ERASE_CYC (ERASE_CYC),
        .PROG_CYC  (PROG_CYC)
      ) u_timer (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .nv      (nv.timer)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [FAWC_NUM_MODULES-1:0] busy_q, done_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rs_q       <= FAWC_RD_IDLE;
      wcnt_q     <= '0;
      next_q     <= '0;
      pf_valid_q <= 1'b0;
      data_q     <= FAWC_ERASED_WORD;
      rdy_q      <= 1'b0;
      hit_q      <= 1'b0;
      acc_q      <= 1'b0;
      ref_q      <= 1'b0;
      busy_q     <= '0;
      done_q     <= '0;
    end else begin
      rs_q       <= rs_d;
      wcnt_q     <= wcnt_d;
      next_q     <= next_d;
      pf_valid_q <= pf_valid_d;
      data_q     <= data_d;
      rdy_q      <= rdy_d;
      hit_q      <= hit_d;
      acc_q      <= acc_d;
      ref_q      <= ref_d;
      busy_q     <= nv_busy_w;
      done_q     <= nv_done_w;
    end
  end

  assign rd_ready       = rdy_q;
  assign rd_data        = data_q;
  assign prefetch_hit   = hit_q;
  assign nv_accept      = acc_q;
  assign nv_refused     = ref_q;
  assign nv_busy        = busy_q;
  assign nv_done        = done_q;
  assign protect_active = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_nonseq_req;
    rs_q == FAWC_RD_IDLE && rd_req && rd_src == FAWC_SRC_FLASH && !seq
      && flash_wait_state_count == 3'h2 && wait_state_extension == 1'b0;
  endsequence

  a_nonseq_wait_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_nonseq_req |=> !rdy_q ##1 !rdy_q ##1 rdy_q)
    else $error("Non-sequential read did not wait two cycles.");

  a_seq_no_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (rs_q == FAWC_RD_IDLE && rd_req && rd_src == FAWC_SRC_FLASH && seq) |=> rdy_q && hit_q)
    else $error("Sequential read was delayed.");

  a_read_lock: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (nv_req && read_active[nv_module]) |=> ref_q && !acc_q)
    else $error("Write on a reading module was accepted.");

  a_spread_single: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (nv_req && n_read > 4'h1 && n_busy != 4'h0 && nv_module != FAWC_FREE_MODULE) |=> ref_q)
    else $error("Second write accepted while reads were spread.");

  a_free_module: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (nv_req && nv_module == FAWC_FREE_MODULE && !read_active[nv_module]
     && !nv_busy_w[nv_module] && n_busy < 4'(FAWC_MAX_PARALLEL)) |=> acc_q)
    else $error("Free module write was refused.");

  a_parallel_cap: assert property (@(posedge clk_sys) disable iff (!reset_n)
    n_busy <= 4'(FAWC_MAX_PARALLEL))
    else $error("Too many parallel writes.");

  a_single_ok: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (nv_req && n_read <= 4'h1 && n_busy == 4'h0 && !read_active[nv_module]) |=> acc_q)
    else $error("Write refused with a single read source.");

  a_no_protect: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !protect_active)
    else $error("Protection shown active.");

  a_busy_after_acc: assert property (@(posedge clk_sys) disable iff (!reset_n)
    acc_q |-> nv_busy_w[$past(nv_module)])
    else $error("Accepted write left no sequencer busy.");

endmodule
`default_nettype wire

// ==== fawc_cpu_model.sv ====
// Processor side model that fetches words over the internal memory bus.
`timescale 1ns/1ns
`default_nettype none
module fawc_cpu_model
  import fawc_pkg::*;
(
  // Clock and reset.
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  // Read bus toward the controller.
  output logic                        rd_req,
  output logic [FAWC_ADDR_W-1:0]      rd_addr,
  output logic [1:0]                  rd_src,
  input  wire logic                   rd_ready,
  input  wire logic [FAWC_DATA_W-1:0] rd_data,
  input  wire logic                   prefetch_hit
);
  initial begin
    rd_req = 1'b0;
    rd_addr = 24'h000000;
    rd_src = FAWC_SRC_NONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One read: request held until one edge after ready is sampled, then the address is
  // scrambled so a released bus never shows the last value.
  // every fetch waits for the controller, for at most 64 edges.
  task automatic fetch(input logic [FAWC_ADDR_W-1:0] addr, output int edges,
                       output logic [FAWC_DATA_W-1:0] data, output logic hit);
    @(posedge clk_sys);
    #1;
    rd_req = 1'b1;
    rd_addr = addr;
    rd_src = FAWC_SRC_FLASH;
    edges = 0;
    do begin
      @(posedge clk_sys);
      #1;
      edges++;
    end while (rd_ready !== 1'b1 && edges < 64);
    data = rd_data;
    hit = prefetch_hit;
    @(posedge clk_sys);
    #1;
    rd_req = 1'b0;
    rd_src = FAWC_SRC_NONE;
    rd_addr = ~rd_addr;
  endtask
endmodule
`default_nettype wire

// ==== fawc_flash_ctrl_tb_top.sv ====
// Self-checking bench for the flash access and wait control block.
`timescale 1ns/1ns
`default_nettype none
module fawc_flash_ctrl_tb_top
  import fawc_pkg::*;
;
  localparam int unsigned ERASE_T = 20;
  localparam int unsigned PROG_T  = 10;

  logic                        clk_sys;
  logic                        reset_n;
  logic [FAWC_WS_W-1:0]        ws;
  logic [FAWC_WSE_W-1:0]       ext;
  logic                        rd_req;
  logic [FAWC_ADDR_W-1:0]      rd_addr;
  logic [1:0]                  rd_src;
  logic [FAWC_DATA_W-1:0]      array_rdata;
  logic                        rd_ready;
  logic [FAWC_DATA_W-1:0]      rd_data;
  logic                        prefetch_hit;
  logic                        nv_req;
  logic                        nv_prog;
  logic [FAWC_MOD_W-1:0]       nv_module;
  logic [FAWC_NUM_MODULES-1:0] read_active;
  logic                        nv_accept;
  logic                        nv_refused;
  logic [FAWC_NUM_MODULES-1:0] nv_busy;
  logic [FAWC_NUM_MODULES-1:0] nv_done;
  logic                        protect_active;
  int                          n_errors;
  int                          check_count;
  integer                      seed;

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  fawc_flash_ctrl #(.ERASE_CYC(ERASE_T), .PROG_CYC(PROG_T)) u_fawc_flash_ctrl (
    .clk_sys(clk_sys), .reset_n(reset_n), .flash_wait_state_count(ws),
    .wait_state_extension(ext), .rd_req(rd_req), .rd_addr(rd_addr), .rd_src(rd_src),
    .array_rdata(array_rdata), .rd_ready(rd_ready), .rd_data(rd_data),
    .prefetch_hit(prefetch_hit), .nv_req(nv_req), .nv_prog(nv_prog),
    .nv_module(nv_module), .read_active(read_active), .nv_accept(nv_accept),
    .nv_refused(nv_refused), .nv_busy(nv_busy), .nv_done(nv_done),
    .protect_active(protect_active));

  fawc_cpu_model u_fawc_cpu_model (
    .clk_sys(clk_sys), .reset_n(reset_n), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_src(rd_src), .rd_ready(rd_ready), .rd_data(rd_data),
    .prefetch_hit(prefetch_hit));

  ////////////////////////////////////////////////////////////////////////////
  // Flash array contents as a fixed scramble of the address.
  function automatic logic [15:0] word_of(input logic [23:0] a);
    return a[15:0] ^ {a[23:16], a[7:0]} ^ 16'h3c5a;
  endfunction

  assign array_rdata = word_of(rd_addr);

  // Edges counted by the fetch for a non-sequential read.
  function automatic int exp_edges(input logic [2:0] w, input logic e);
    int t;
    t = int'(w) + int'(e);
    if (t == 0) begin
      t = 1;
    end
    return t + 1;
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [23:0] a, input int exp_e, input logic exp_hit);
    int          e;
    logic [15:0] d;
    logic        h;
    u_fawc_cpu_model.fetch(a, e, d, h);
    chk("rd_edges", e, exp_e);
    chk("rd_data", d, word_of(a));
    chk("prefetch_hit", h, exp_hit);
    if (e >= 64) begin
      end_sim();
    end
  endtask

  task automatic nv_op(input logic [7:0] act, input logic [2:0] m, input logic p,
                       input logic acc);
    @(posedge clk_sys);
    #1;
    read_active = act;
    nv_req = 1'b1;
    nv_prog = p;
    nv_module = m;
    @(posedge clk_sys);
    #1;
    nv_req = 1'b0;
    chk("nv_accept", nv_accept, acc);
    chk("nv_refused", nv_refused, !acc);
  endtask

  task automatic wait_done(input logic [2:0] m, input int n);
    int c;
    c = 0;
    do begin
      @(posedge clk_sys);
      #1;
      c++;
    end while (nv_done[m] !== 1'b1 && c < 200);
    chk("nv_time", (c > n && c <= n + 16), 1);
    if (c >= 200) begin
      end_sim();
    end
  endtask

  task automatic idle_wait();
    int c;
    c = 0;
    while (nv_busy !== 8'h00 && c < 300) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
    chk("nv_busy_idle", nv_busy, 0);
    if (c >= 300) begin
      end_sim();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [23:0] a;
    int          k;
    logic [2:0]  r;
    logic [2:0]  m;
    seed = 32'hbe4d2a53;
    n_errors = 0;
    check_count = 0;
    reset_n = 1'b0;
    ws = 3'h2;
    ext = 1'b0;
    nv_req = 1'b0;
    nv_prog = 1'b0;
    nv_module = 3'h0;
    read_active = 8'h00;
    repeat (16) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    chk("rd_data_rst", rd_data, FAWC_ERASED_WORD);
    chk("protect_rst", protect_active, 0);
    chk("nv_busy_rst", nv_busy, 0);
    $display("test reset done");
    for (k = 0; k < 14; k++) begin
      @(posedge clk_sys);
      #1;
      // settings legal at a 10 MHz clock.
      ws = (k == 0) ? 3'h2 : (k == 1) ? 3'h7 : 3'(2 + ($unsigned($random(seed)) % 6));
      ext = (k == 0) ? 1'b0 : (k == 1) ? 1'b1 : 1'($random(seed));
      a = 24'($random(seed)) & 24'hfffff0;
      rd_chk(a, exp_edges(ws, ext), 1'b0);
      rd_chk(a + 24'h000001, 1, 1'b1);
    end
    $display("test reads done");
    nv_op(8'h00, 3'h5, 1'b0, 1'b1);
    wait_done(3'h5, ERASE_T);
    nv_op(8'h00, 3'h4, 1'b1, 1'b1);
    wait_done(3'h4, PROG_T);
    $display("test timing done");
    for (k = 1; k < 8; k++) begin
      nv_op(8'h01, 3'(k), 1'b0, 1'b1);
    end
    nv_op(8'h01, 3'h0, 1'b0, 1'b0);
    nv_op(8'h01, 3'h3, 1'b1, 1'b0);
    idle_wait();
    $display("test parallel done");
    nv_op(8'h03, 3'h2, 1'b0, 1'b1);
    nv_op(8'h03, 3'h3, 1'b0, 1'b0);
    nv_op(8'h03, 3'h6, 1'b1, 1'b1);
    nv_op(8'h03, 3'h1, 1'b1, 1'b0);
    idle_wait();
    $display("test multi reader done");
    for (k = 0; k < 6; k++) begin
      r = 3'($random(seed));
      m = 3'($random(seed));
      nv_op(8'h01 << r, m, 1'($random(seed)), m != r);
      idle_wait();
    end
    chk("protect_end", protect_active, 0);
    $display("test random writes done");
    end_sim();
  end
endmodule
`default_nettype wire
